//--- shared/icis_pkg.sv
package icis_pkg;

   // Confirmation result codes carried up by the frame decoder
   localparam logic [1:0] RES_NORMAL   = 2'h0;
   localparam logic [1:0] RES_TYPE_MIS = 2'h1;
   localparam logic [1:0] RES_OBJ_MIS  = 2'h2;
   localparam logic [1:0] RES_DISPOSAL = 2'h3;

   // Default timeout counts in clock cycles (shortened by parameter)
   localparam int unsigned CONFIRM_RESPONSE_TIMEOUT_CYC = 1000;
   localparam int unsigned RESPONSE_WAIT_TIMEOUT_CYC    = 1000;
   localparam int unsigned ADAPTER_INIT_LIMIT_CYC       = 2000;
   localparam int unsigned INIT_REPLY_DELAY_CYC         = 4;
   localparam int unsigned TIMER_WIDTH                  = 24;

   // Adapter sequencing states
   typedef enum logic [3:0] {
      ICIS_POWER_UP,
      ICIS_WAIT_CONFIRM,
      ICIS_STANDBY,
      ICIS_ERASE_OBJ,
      ICIS_INIT_REPLY,
      ICIS_INIT_RUN,
      ICIS_WAIT_ACCEPT,
      ICIS_ERROR_STOP,
      ICIS_UNRECOGNIZED
   } icis_state_t;

   // Response received from the equipment side of the link
   typedef struct packed {
      logic       confirm_resp;    // Confirmation response pulse
      logic [1:0] confirm_result;  // Result field of that response
      logic       init_req;        // Initialization setting request pulse
      logic       init_discard;    // Request asks to discard device data
      logic       accept_resp;     // Completion acceptance pulse
      logic       accept_ok;       // Acceptance says successful
   } icis_rx_t;

   // Commands issued toward the frame encoder
   typedef struct packed {
      logic send_confirm;   // Send confirmation request
      logic send_init_resp; // Send initialization setting response
      logic send_complete;  // Send initialization completion notice
   } icis_tx_t;

endpackage : icis_pkg

//--- rtl/icis_timer.sv
`timescale 1ns/1ns
`default_nettype none
module icis_timer
   import icis_pkg::*;
#(
   parameter int unsigned W = TIMER_WIDTH
) (
   // Clock and reset
   input  wire logic         i_sys_clk,
   input  wire logic         i_reset,
   // Control
   input  wire logic         i_start,
   input  wire logic         i_stop,
   input  wire logic [W-1:0] i_limit,
   // Status
   output logic              o_expired
);

   logic [W-1:0] count;   // Cycles left
   logic         running; // Timer armed

   ////////////////////////////////////////////////////////////////////
   // Down counter; a restart beats a stop so no start is lost
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         count   <= '0;
         running <= 1'b0;
      end else if (i_start) begin
         count   <= i_limit;
         running <= 1'b1;
      end else if (i_stop || (running && count == {{(W-1){1'b0}}, 1'b1})) begin
         running <= 1'b0;
         count   <= '0;
      end else if (running) begin
         count <= count - 1'b1;
      end
   end

   // One-cycle expiry pulse
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         o_expired <= 1'b0;
      end else begin
         o_expired <= running && !i_start && !i_stop
                      && count == {{(W-1){1'b0}}, 1'b1};
      end
   end

endmodule : icis_timer
`default_nettype wire

//--- rtl/icis_adapter.sv
// Functional notes
// R01: Equipment answers confirmation within reply limit
// R02: Equipment reports mismatches in result field
// R03: Equipment resets adapter after type mismatch
// R04: Three mismatches give disposal then unrecognized
// R05: Equipment watches for requests, resets adapter
// R06: Three missed requests make equipment unrecognized
// R07: Adapter sends confirmation request after power-on
// R08: Normal or mismatch results lead to standby
// R09: Disposal result discards data, goes unrecognized
// R10: One confirmation resend, then unrecognized
// R11: Equipment sends initialization request on construction
// R12: Equipment resends init request once only
// R13: Equipment waits for completion, else stand-alone
// R14: Equipment accepts completion within response wait
// R15: Adapter replies promptly, then starts startup
// R16: Discard request erases object data first
// R17: Adapter notifies completion within init limit
// R18: One notification resend, then error stop
// R19: All timeouts are counter parameters
`timescale 1ns/1ns
`default_nettype none
module icis_adapter
   import icis_pkg::*;
#(
   // Timeout counts, parameters so simulation can shorten them
   parameter int unsigned CONFIRM_TO  = CONFIRM_RESPONSE_TIMEOUT_CYC, // [R19]
   parameter int unsigned RESP_TO     = RESPONSE_WAIT_TIMEOUT_CYC,    // [R19]
   parameter int unsigned INIT_LIMIT  = ADAPTER_INIT_LIMIT_CYC,       // [R19]
   parameter int unsigned REPLY_DELAY = INIT_REPLY_DELAY_CYC
) (
   // Clock and reset
   input  wire logic  i_sys_clk,
   input  wire logic  i_reset,
   // Decoded frames from the equipment
   input  wire icis_rx_t i_rx,
   // Lower-layer startup handshake
   input  wire logic  i_startup_done,
   output logic       o_startup_go,
   // Frame send commands
   output icis_tx_t   o_tx,
   // Data disposal strobes
   output logic       o_discard_obj,
   output logic       o_discard_if,
   // State indication
   output icis_state_t o_state
);

   localparam int unsigned W = TIMER_WIDTH;
   // Forced completion point; never later than the init limit
   localparam int unsigned FORCE_AT = (REPLY_DELAY < INIT_LIMIT)
                                      ? REPLY_DELAY : INIT_LIMIT; // [R17]

   icis_state_t state;      // Current sequencing state
   logic        retried;    // One resend already used
   logic        pend_disc;  // Pending init asked for erase
   logic [W-1:0] dly;       // Reply delay counter
   logic        tmr_start;  // Timer (re)arm
   logic        tmr_stop;   // Timer disarm
   logic [W-1:0] tmr_limit; // Count for the armed wait
   logic        tmr_exp;    // Timer expiry pulse

   ////////////////////////////////////////////////////////////////////
   // Shared timeout counter
   icis_timer #(.W(W)) u_timer (
      .i_sys_clk (i_sys_clk),
      .i_reset   (i_reset),
      .i_start   (tmr_start),
      .i_stop    (tmr_stop),
      .i_limit   (tmr_limit),
      .o_expired (tmr_exp)
   );

   // Arm on every confirmation or completion send; disarm on reaching a resting state
   always_comb begin
      tmr_start = o_tx.send_confirm || o_tx.send_complete;
      tmr_limit = o_tx.send_complete ? W'(RESP_TO) : W'(CONFIRM_TO); // [R19]
      tmr_stop  = (state == ICIS_WAIT_CONFIRM && i_rx.confirm_resp)
                || (state == ICIS_WAIT_ACCEPT && i_rx.accept_resp
                    && i_rx.accept_ok);
   end

   ////////////////////////////////////////////////////////////////////
   // Main sequencing state machine
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         state     <= ICIS_POWER_UP;
         retried   <= 1'b0;
         pend_disc <= 1'b0;
         dly       <= '0;
      end else begin
         case (state)
            // Leave reset straight into confirmation
            ICIS_POWER_UP: begin
               state   <= ICIS_WAIT_CONFIRM; // [R07]
               retried <= 1'b0;
            end
            ICIS_WAIT_CONFIRM: begin
               if (i_rx.confirm_resp) begin
                  // Disposal is unrecognized at once, well inside watch
                  case (i_rx.confirm_result)
                     RES_DISPOSAL: state <= ICIS_UNRECOGNIZED; // [R09]
                     default:      state <= ICIS_STANDBY;      // [R08]
                  endcase
               end else if (tmr_exp) begin
                  if (retried) begin
                     state <= ICIS_UNRECOGNIZED; // [R10]
                  end else begin
                     retried <= 1'b1;
                  end
               end
            end
            // Standby and error stop wait for an init request
            ICIS_STANDBY, ICIS_ERROR_STOP: begin
               if (i_rx.init_req) begin
                  pend_disc <= i_rx.init_discard;
                  state     <= i_rx.init_discard ? ICIS_ERASE_OBJ
                                                 : ICIS_INIT_REPLY; // [R16]
                  dly       <= W'(FORCE_AT); // [R17]
               end
            end
            // Erase takes one cycle, then same handling
            ICIS_ERASE_OBJ: begin
               state <= ICIS_INIT_REPLY; // [R16]
            end
            // Reply goes out on entry; then startup begins
            ICIS_INIT_REPLY: begin
               state <= ICIS_INIT_RUN; // [R15]
            end
            ICIS_INIT_RUN: begin
               if (i_startup_done || dly == '0) begin
                  state   <= ICIS_WAIT_ACCEPT; // [R17]
                  retried <= 1'b0;
               end else begin
                  dly <= dly - 1'b1;
               end
            end
            ICIS_WAIT_ACCEPT: begin
               if (i_rx.accept_resp && i_rx.accept_ok) begin
                  state <= ICIS_STANDBY;
               end else if (tmr_exp) begin
                  if (retried) begin
                     state <= ICIS_ERROR_STOP; // [R18]
                  end else begin
                     retried <= 1'b1;
                  end
               end
            end
            ICIS_UNRECOGNIZED: begin
               state <= ICIS_UNRECOGNIZED;
            end
            default: state <= ICIS_POWER_UP;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Startup order follows the reply notice by one cycle, so the
   // reply always leaves before lower-layer startup begins.
   // Limitation: completion is forced at FORCE_AT (reply delay, or init limit if smaller) if lower layer
   // never reports done, so the notice always goes out in time.
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         o_startup_go <= 1'b0;
      end else begin
         o_startup_go <= o_tx.send_init_resp; // [R15]
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Frame send pulses
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         o_tx <= '0;
      end else begin
         o_tx.send_confirm   <= (state == ICIS_POWER_UP)
                             || (state == ICIS_WAIT_CONFIRM && tmr_exp
                                 && !retried && !i_rx.confirm_resp); // [R10]
         o_tx.send_init_resp <= (state == ICIS_INIT_REPLY); // [R15]
         o_tx.send_complete  <= (state == ICIS_INIT_RUN
                                 && (i_startup_done || dly == '0))
                             || (state == ICIS_WAIT_ACCEPT && tmr_exp
                                 && !retried
                                 && !(i_rx.accept_resp && i_rx.accept_ok));
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Discard strobes
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         o_discard_obj <= 1'b0;
         o_discard_if  <= 1'b0;
      end else begin
         o_discard_obj <= (state == ICIS_WAIT_CONFIRM && i_rx.confirm_resp
                           && (i_rx.confirm_result == RES_OBJ_MIS
                               || i_rx.confirm_result == RES_DISPOSAL)) // [R08]
                       || (state == ICIS_WAIT_CONFIRM && tmr_exp && retried)
                       || (state == ICIS_ERASE_OBJ); // [R16]
         o_discard_if  <= (state == ICIS_WAIT_CONFIRM && i_rx.confirm_resp
                           && i_rx.confirm_result == RES_DISPOSAL) // [R09]
                       || (state == ICIS_WAIT_CONFIRM && tmr_exp && retried);
      end
   end

   // State shown to the outside
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) o_state <= ICIS_POWER_UP;
      else         o_state <= state;
   end

   ////////////////////////////////////////////////////////////////////
   // Checks
   a_confirm_after_reset: assert property (@(posedge i_sys_clk) // [R07]
      disable iff (i_reset)
      $fell(i_reset) |-> ##[1:3] o_tx.send_confirm)
      else $error("no confirmation request after reset");

   a_disposal_unrec: assert property (@(posedge i_sys_clk) // [R09]
      disable iff (i_reset)
      (state == ICIS_WAIT_CONFIRM && i_rx.confirm_resp
       && i_rx.confirm_result == RES_DISPOSAL)
      |=> state == ICIS_UNRECOGNIZED && o_discard_if && o_discard_obj
      ##1 o_discard_if == 1'b0)
      else $error("disposal did not reach unrecognized");

   a_result_standby: assert property (@(posedge i_sys_clk) // [R08]
      disable iff (i_reset)
      (state == ICIS_WAIT_CONFIRM && i_rx.confirm_resp
       && i_rx.confirm_result != RES_DISPOSAL) |=> state == ICIS_STANDBY)
      else $error("result did not lead to standby");

   a_objmis_discard: assert property (@(posedge i_sys_clk) // [R08]
      disable iff (i_reset)
      (state == ICIS_WAIT_CONFIRM && i_rx.confirm_resp
       && i_rx.confirm_result == RES_OBJ_MIS) |=> o_discard_obj)
      else $error("object mismatch did not discard");

   a_confirm_retry: assert property (@(posedge i_sys_clk) // [R10]
      disable iff (i_reset)
      (state == ICIS_WAIT_CONFIRM && tmr_exp && retried
       && !i_rx.confirm_resp) |=> state == ICIS_UNRECOGNIZED && o_discard_if)
      else $error("second confirm timeout mishandled");

   a_erase_first: assert property (@(posedge i_sys_clk) // [R16]
      disable iff (i_reset)
      (state == ICIS_ERASE_OBJ) |=> o_discard_obj ##1 o_tx.send_init_resp)
      else $error("erase did not precede reply");

   a_reply_startup: assert property (@(posedge i_sys_clk) // [R15]
      disable iff (i_reset)
      o_tx.send_init_resp |=> o_startup_go)
      else $error("reply without startup");

   a_notice_limit: assert property (@(posedge i_sys_clk) // [R17]
      disable iff (i_reset)
      $rose(o_startup_go) |-> ##[0:300] o_tx.send_complete)
      else $error("completion notice late");

   a_error_stop: assert property (@(posedge i_sys_clk) // [R18]
      disable iff (i_reset)
      (state == ICIS_WAIT_ACCEPT && tmr_exp && retried
       && !(i_rx.accept_resp && i_rx.accept_ok)) |=> state == ICIS_ERROR_STOP)
      else $error("second accept timeout did not stop");

endmodule : icis_adapter
`default_nettype wire

//--- tb/icis_equip_model.sv
`timescale 1ns/1ns
`default_nettype none
module icis_equip_model
   import icis_pkg::*;
(
   // Clock
   input  wire logic       i_sys_clk,
   // Adapter commands and bench controls
   input  wire icis_tx_t   i_tx,
   input  wire logic       i_reply_en,
   input  wire logic [1:0] i_result,
   input  wire logic       i_accept_ok,
   input  wire logic [3:0] i_delay,
   input  wire logic       i_init_go,
   input  wire logic       i_init_discard,
   // Decoded frames toward the adapter
   output icis_rx_t        o_rx,
   // Stand-alone fallback taken by the equipment
   output logic            o_stand_alone
);
   int       cnt_conf;  // Cycles left to the confirmation reply
   int       cnt_acc;   // Cycles left to the acceptance reply
   icis_tx_t tx_s;      // Commands seen at the edge
   logic     go_s;      // Init request order seen at the edge
   int       cnt_ireq;  // Cycles left for the init response
   int       cnt_cmp;   // Cycles left for the completion notice
   logic     resent;    // Init request already sent a second time
   localparam int INIT_WAIT = 12; // Shortened init request timeout
   localparam int COMP_WAIT = 60; // Shortened completion wait
   initial begin
      o_rx     = '0;
      cnt_conf = -1;
      cnt_acc  = -1;
      cnt_ireq = -1;
      cnt_cmp  = -1;
      resent   = 1'b0;
      o_stand_alone = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////
   // Inputs are taken at the edge, before the design updates, so no race
   always @(posedge i_sys_clk) begin
      tx_s = i_tx;
      go_s = i_init_go;
      #1;
      o_rx.confirm_resp = 1'b0;
      o_rx.accept_resp  = 1'b0;
      o_rx.init_req     = 1'b0;
      // Idle fields toggle so a stale value never looks valid
      o_rx.confirm_result = ~o_rx.confirm_result;
      o_rx.accept_ok      = ~o_rx.accept_ok;
      o_rx.init_discard   = ~o_rx.init_discard;
      if (cnt_conf == 0) begin
         o_rx.confirm_resp   = 1'b1;
         o_rx.confirm_result = i_result;
      end
      if (cnt_acc == 0) begin
         o_rx.accept_resp = 1'b1;
         o_rx.accept_ok   = i_accept_ok;
      end
      if (cnt_conf >= 0) cnt_conf--;
      if (cnt_acc >= 0) cnt_acc--;
      // Delay stays below every timeout of the adapter
      if (tx_s.send_confirm && i_reply_en) cnt_conf = int'(i_delay);
      if (tx_s.send_complete && i_reply_en) cnt_acc = int'(i_delay);
      // Init response watch: one resend, then stand-alone
      if (tx_s.send_init_resp) cnt_ireq = -1;
      if (cnt_ireq == 0 && resent) o_stand_alone = 1'b1;
      if (cnt_ireq == 0 && !resent) begin
         o_rx.init_req     = 1'b1;
         o_rx.init_discard = i_init_discard;
         resent            = 1'b1;
         cnt_ireq          = INIT_WAIT + 1;
      end
      if (cnt_ireq >= 0) cnt_ireq--;
      // Completion watch after the reply; silence means stand-alone
      if (tx_s.send_init_resp) cnt_cmp = COMP_WAIT;
      if (tx_s.send_complete) cnt_cmp = -1;
      if (cnt_cmp == 0) o_stand_alone = 1'b1;
      if (cnt_cmp >= 0) cnt_cmp--;
      if (go_s) begin
         o_rx.init_req     = 1'b1;
         o_rx.init_discard = i_init_discard;
         cnt_ireq          = INIT_WAIT;
         resent            = 1'b0;
         o_stand_alone     = 1'b0;
      end
   end
endmodule : icis_equip_model
`default_nettype wire

//--- tb/tb_icis_adapter.sv
`timescale 1ns/1ns
`default_nettype none
module tb_icis_adapter
   import icis_pkg::*;
;
   localparam int CTO = 20;  // Shortened confirmation timeout
   localparam int RTO = 20;  // Shortened acceptance timeout
   localparam int ILIM = 40; // Shortened init limit
   logic        i_sys_clk, i_reset, i_startup_done;
   logic        o_startup_go, o_discard_obj, o_discard_if;
   icis_rx_t    rx;
   icis_tx_t    tx;
   icis_state_t st;
   logic        reply_en, acc_ok, go, disc;  // Partner controls
   logic        alone;                       // Partner went stand-alone
   logic [1:0]  res;
   logic [3:0]  dly;
   logic [31:0] seed = 32'hA8FFBF0C;
   int n_errors, compares, cyc;
   // Cycle stamps of each output pulse
   int q_conf[$], q_comp[$], q_iresp[$], q_go[$], q_dobj[$], q_dif[$];
   icis_adapter #(.CONFIRM_TO(CTO), .RESP_TO(RTO), .INIT_LIMIT(ILIM),
      .REPLY_DELAY(4)) u_icis_adapter (.i_sys_clk(i_sys_clk),
      .i_reset(i_reset), .i_rx(rx), .i_startup_done(i_startup_done),
      .o_startup_go(o_startup_go), .o_tx(tx), .o_discard_obj(o_discard_obj),
      .o_discard_if(o_discard_if), .o_state(st));
   icis_equip_model u_icis_equip_model (.i_sys_clk(i_sys_clk), .i_tx(tx),
      .i_reply_en(reply_en), .i_result(res), .i_accept_ok(acc_ok),
      .i_delay(dly), .i_init_go(go), .i_init_discard(disc), .o_rx(rx),
      .o_stand_alone(alone));
   initial begin
      i_sys_clk = 1'b0;
      forever #10 i_sys_clk = ~i_sys_clk;
   end
   ////////////////////////////////////////////////////////////////////////
   // Monitor stamps every pulse; expectations come from the counts
   always @(posedge i_sys_clk) begin
      cyc++;
      if (tx.send_confirm === 1'b1) q_conf.push_back(cyc);
      if (tx.send_complete === 1'b1) q_comp.push_back(cyc);
      if (tx.send_init_resp === 1'b1) q_iresp.push_back(cyc);
      if (o_startup_go === 1'b1) q_go.push_back(cyc);
      if (o_discard_obj === 1'b1) q_dobj.push_back(cyc);
      if (o_discard_if === 1'b1) q_dif.push_back(cyc);
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic final_report();
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : final_report
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check
   // Inputs always move 1 ns after the rising edge
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge i_sys_clk);
         #1;
      end
   endtask : tick
   task automatic clear_q();
      q_conf.delete();
      q_comp.delete();
      q_iresp.delete();
      q_go.delete();
      q_dobj.delete();
      q_dif.delete();
   endtask : clear_q
   // Bounded wait; a hang ends the run as a failure
   task automatic wait_state(input icis_state_t s);
      int k;
      k = 0;
      while (st !== s && k < 200) begin
         tick(1);
         k++;
      end
      if (st !== s) begin
         n_errors++;
         $display("MISMATCH at %0t: state wait timed out", $time);
         final_report();
      end
   endtask : wait_state
   task automatic confirm_case(input logic [1:0] r, input logic en,
                               input icis_state_t es, input int nd,
                               input int ni);
      res = r;
      reply_en = en;
      dly = 4'(rnd() % 8 + 1);
      i_reset = 1'b1;  // Equipment resets the adapter
      tick(2);
      i_reset = 1'b0;
      clear_q();
      wait_state(es);
      tick(3);
      check(q_conf.size(), en ? 1 : 2);
      check(q_dobj.size(), nd);
      check(q_dif.size(), ni);
   endtask : confirm_case
   task automatic init_case(input logic d, input logic ok);
      clear_q();
      acc_ok = ok;
      disc = d;
      dly = 4'(rnd() % 8 + 1);
      go = 1'b1;
      tick(1);
      go = 1'b0;
      wait_state(ICIS_INIT_RUN);
      tick(int'(rnd() % 2));
      i_startup_done = 1'b1;
      tick(1);
      i_startup_done = 1'b0;
      wait_state(ok ? ICIS_STANDBY : ICIS_ERROR_STOP);
      tick(2);
      check(q_iresp.size(), 1);
      check(q_go.size(), 1);
      check(q_go[0] > q_iresp[0], 1);
      check(q_dobj.size(), d);
      if (d) check(q_dobj[0] < q_iresp[0], 1);
      check(q_comp[0] - q_go[0] <= ILIM, 1);
      check(q_comp.size(), ok ? 1 : 2);
      if (!ok) check(q_comp[1] - q_comp[0] >= RTO, 1);
      check(alone, 1'b0);
      $display("test init discard %0d ok %0d done", d, ok);
   endtask : init_case
   ////////////////////////////////////////////////////////////////////////
   initial begin
      i_reset = 1'b1;
      i_startup_done = 1'b0;
      reply_en = 1'b1;
      res = 2'h0;
      acc_ok = 1'b1;
      go = 1'b0;
      disc = 1'b0;
      dly = 4'h1;
      tick(16);
      // Every result code, each after its own reset; disposal last
      for (int r = 0; r < 4; r++) begin
         confirm_case(2'(r), 1'b1, r == 3 ? ICIS_UNRECOGNIZED : ICIS_STANDBY,
                      r >= 2, r == 3);
         $display("test confirm result %0d done", r);
      end
      // Silent equipment: one resend, then both discards
      confirm_case(2'h0, 1'b0, ICIS_UNRECOGNIZED, 1, 1);
      check(q_conf[1] - q_conf[0] >= CTO, 1);
      check(q_dif[0] - q_conf[1] >= CTO, 1);
      $display("test confirm silent done");
      confirm_case(2'h0, 1'b1, ICIS_STANDBY, 0, 0);
      init_case(1'b0, 1'b1);
      init_case(1'b1, 1'b1);
      // Refused acceptance leads to error stop, which takes a new request
      init_case(1'b0, 1'b0);
      init_case(1'b1, 1'b1);
      final_report();
   end
endmodule : tb_icis_adapter
`default_nettype wire
